// file: dv/tb_top.sv
// Self-checking bench for the trigger control slice
`timescale 1ns/1ps
`include "trigger_defines.svh"
module tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [63:0] sys_time = 64'h100;
    logic [63:0] target_time = 64'h0;
    logic [2:0]  upstream_done = 3'h0;
    logic [31:0] hrdata, rs = 32'h99a6;
    logic        hready, hresp, unit_done, trig_out, irq, t0;
    logic        rph_r = 1'b0;
    logic [31:0] exp_q[$];
    int          fails = 0, checks_done = 0, ndone = 0, n0, k;

    always #25 hclk = ~hclk;
    always @(posedge hclk) sys_time <= sys_time + 64'h1;

    trigger_output_cascade_control #(.ITER_W(16), .TIME_W(64)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .sys_time(sys_time), .target_time(target_time),
        .upstream_done(upstream_done), .unit_done(unit_done),
        .trig_out(trig_out), .irq(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One single AHB-Lite transfer, waiting on hready
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Read data compared against the oldest note
    always @(posedge hclk) begin
        if (rph_r && hready === 1'b1 && exp_q.size() > 0)
            chk(hrdata, exp_q.pop_front());
        rph_r <= hsel && htrans[1] && !hwrite && hready;
    end

    always @(posedge hclk) if (unit_done === 1'b1) ndone++;

    task automatic pulse(input int i);
        upstream_done <= 3'h1 << i;
        @(posedge hclk);
        upstream_done <= 3'h0;
        tick(6);
    endtask

    // Enable once with a passed target, then check outcome
    task automatic fire(input logic [31:0] c, input int dn,
                        input logic [31:0] st, input logic ir);
        wr(`TRG_CTRL_ADDR, c);
        t0 = trig_out;
        n0 = ndone;
        wr(`TRG_RUN_ADDR, 32'h1);
        tick(6);
        chk(ndone - n0, dn);
        chk(trig_out, t0 ^ (dn != 0));
        chk(irq, ir);
        rd(`TRG_RUN_ADDR, 32'h0);
        rd(`TRG_STAT_ADDR, st);
        chk(irq, 1'b0);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        complete_run;
    end

    initial begin
        tick(6);
        hresetn <= 1'b1;
        tick(2);
        rd(`TRG_CTRL_ADDR, 32'h0);
        rd(`TRG_RUN_ADDR, 32'h0);
        rd(`TRG_STAT_ADDR, 32'h0);
        rd(`TRG_MASK_ADDR, 32'h0);
        rd(12'h53c, 32'h0);
        chk({hready, hresp}, 2'b10);
        chk(trig_out, 1'b0);
        $display("test reset ended");
        repeat (4) begin
            rs = xs(rs);
            wr(`TRG_CTRL_ADDR, rs);
            rd(`TRG_CTRL_ADDR, rs & `TRG_CTRL_WMASK);
        end
        $display("test fields ended");
        wr(`TRG_MASK_ADDR, 32'h1);
        target_time <= sys_time - 64'h20;
        fire(32'h03000000, 1, 32'h1, 1'b1);
        fire(32'h02800000, 1, 32'h0, 1'b0);
        fire(32'h01000000, 0, 32'h2, 1'b0);
        $display("test immediate ended");
        target_time <= sys_time + 64'h40;
        wr(`TRG_CTRL_ADDR, 32'h01000000);
        n0 = ndone;
        wr(`TRG_RUN_ADDR, 32'h1);
        rd(`TRG_RUN_ADDR, 32'h5);
        tick(20);
        chk(ndone - n0, 0);
        tick(60);
        chk(ndone - n0, 1);
        rd(`TRG_STAT_ADDR, 32'h1);
        $display("test wait ended");
        target_time <= sys_time + 64'h40;
        n0 = ndone;
        wr(`TRG_RUN_ADDR, 32'h1);
        wr(`TRG_RUN_ADDR, 32'h2);
        rd(`TRG_CTRL_ADDR, 32'h0);
        rd(`TRG_RUN_ADDR, 32'h0);
        tick(80);
        chk(ndone - n0, 0);
        $display("test soft clear ended");
        target_time <= sys_time - 64'h20;
        for (int s = 1; s <= 3; s++) begin
            wr(`TRG_CTRL_ADDR, 32'h82000000 | (s << 26));
            n0 = ndone;
            pulse(s % 3);
            chk(ndone - n0, 0);
            pulse(s - 1);
            chk(ndone - n0, 1);
        end
        wr(`TRG_CTRL_ADDR, 32'h06000000);
        n0 = ndone;
        pulse(0);
        chk(ndone - n0, 0);
        $display("test chain select ended");
        rs = xs(rs);
        k = rs[1:0] + 1;
        wr(`TRG_CTRL_ADDR, 32'hc6000000 | k);
        t0 = trig_out;
        n0 = ndone;
        repeat (k + 1) pulse(0);
        chk(ndone - n0, k);
        chk(trig_out, t0 ^ k[0] ^ 1'b1);
        wr(`TRG_CTRL_ADDR, 32'h86000000);
        n0 = ndone;
        repeat (4) pulse(0);
        chk(ndone - n0, 4);
        $display("test iteration ended");
        complete_run;
    end
endmodule // tb_top

// file: dv/trig_ctl_chk.sv
// Assertion checker for the trigger control slice
`timescale 1ns/1ps
`include "trigger_defines.svh"
module trig_ctl_chk #(parameter int TIME_W = 64) (
    // Bus and clock
    input wire logic              hclk, hresetn, hsel, hwrite, hready,
    input wire logic [31:0]       haddr, hwdata,
    input wire logic [1:0]        htrans,
    // Time, cascade and outputs
    input wire logic [TIME_W-1:0] sys_time, target_time,
    input wire logic [2:0]        upstream_done,
    input wire logic              unit_done, trig_out, irq
);
    logic        wph_r, neg_r, run_wr, late, reached;
    logic [11:0] wad_r;
    logic [31:0] ctl_r;
    logic [1:0]  msk_r, sel;
    assign run_wr  = wph_r && wad_r == `TRG_RUN_ADDR && hwdata[0];
    assign late    = target_time < sys_time;
    assign reached = sys_time >= target_time;
    assign sel     = ctl_r[27:26];
    // Shadow of control and mask words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_r <= 1'b0;
            wad_r <= 12'h0;
            ctl_r <= 32'h0;
            msk_r <= 2'h0;
        end else if (hready) begin
            wph_r <= hsel && htrans[1] && hwrite;
            wad_r <= haddr[11:0];
            if (wph_r && wad_r == `TRG_CTRL_ADDR) ctl_r <= hwdata;
            if (wph_r && wad_r == `TRG_MASK_ADDR) msk_r <= hwdata[1:0];
            if (wph_r && wad_r == `TRG_RUN_ADDR && hwdata[1])
                ctl_r <= 32'h0;
        end
    end
    // Output level seen at each falling edge
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) neg_r <= 1'b0;
        else neg_r <= trig_out;
    end
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_done_pulse: assert property (unit_done |=> !unit_done)
        else $error("done pulse held");
    a_rise_launch: assert property (
        !ctl_r[23] |-> trig_out == neg_r)
        else $error("output moved off the rising edge");
    a_fall_launch: assert property (
        ctl_r[23] |-> neg_r == $past(trig_out))
        else $error("output moved off the falling edge");
    a_notify_irq: assert property ($rose(irq) |-> ctl_r[24])
        else $error("interrupt without notify");
    a_irq_mask: assert property (
        irq |-> (msk_r | $past(msk_r)) != 2'h0)
        else $error("interrupt while masked");
    a_now_fire: assert property (
        run_wr ##1 (ctl_r[25] && !ctl_r[30] && late) |-> ##[1:3] unit_done)
        else $error("immediate fire missing");
    a_late_fault: assert property (
        run_wr ##1 (!ctl_r[25] && late) |=> !unit_done [*4])
        else $error("fired on a passed target");
    a_wait_time: assert property (unit_done |-> $past(reached, 2))
        else $error("fired before target time");
    a_chain_start: assert property (
        ctl_r[31] && !ctl_r[30] && ctl_r[25] && late && sel != 2'h0
        && upstream_done[sel - 2'h1] |-> ##[1:3] unit_done)
        else $error("selected upstream done ignored");
    c_fall: cover property (unit_done && ctl_r[23]);
    c_irq: cover property ($rose(irq));
    c_chain: cover property (unit_done && ctl_r[31]);
endmodule // trig_ctl_chk

bind trigger_output_cascade_control trig_ctl_chk #(.TIME_W(TIME_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite),
    .hready(hready), .haddr(haddr), .hwdata(hwdata), .htrans(htrans),
    .sys_time(sys_time), .target_time(target_time),
    .upstream_done(upstream_done), .unit_done(unit_done),
    .trig_out(trig_out), .irq(irq));

// file: hw/ahb_lite_regport.sv
// Zero-wait AHB-Lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
`include "trigger_defines.svh"

module ahb_lite_regport (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave side
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Register side
    output logic                        wr_en,
    output logic      [`TRG_ADDR_W-1:0] wr_addr,
    output logic      [31:0]            wr_data,
    output logic                        rd_en,
    output logic      [`TRG_ADDR_W-1:0] rd_addr,
    input  wire logic [31:0]            rd_data
);
    typedef struct packed {
        logic                   wr_pend;
        logic [`TRG_ADDR_W-1:0] wr_addr;
        logic [31:0]            rdata;
        logic                   ready;
    } port_state_type;

    port_state_type s_r;
    port_state_type s_nxt;
    logic           take;

    // Address phase accepted on NONSEQ or SEQ; hsize is not decoded, so every access acts as a whole word
    assign take    = hsel & htrans[1] & hready;
    assign rd_en   = take & ~hwrite;
    assign rd_addr = haddr[`TRG_ADDR_W-1:0];
    assign wr_en   = s_r.wr_pend;
    assign wr_addr = s_r.wr_addr;
    assign wr_data = hwdata;

    assign hrdata    = s_r.rdata;
    assign hreadyout = s_r.ready;
    assign hresp     = 1'b0;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.ready   = 1'b1;
        s_nxt.wr_pend = take & hwrite;
        if (take) begin
            s_nxt.wr_addr = haddr[`TRG_ADDR_W-1:0];
        end
        // Read data captured so it stands in the data phase
        if (rd_en) begin
            s_nxt.rdata = rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // ahb_lite_regport

// file: hw/trigger_edge_launch.sv
// Launches the trigger output on the chosen edge of the system clock
`timescale 1ns/1ps

module trigger_edge_launch (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Launch request
    input  wire logic fire,
    input  wire logic on_falling,
    // Output level
    output logic      trig_out
);
    typedef struct packed {
        logic rise_tgl;
        logic fall_req;
    } launch_state_type;

    launch_state_type s_r;
    launch_state_type s_nxt;
    logic             fall_tgl_r;

    always_comb begin
        s_nxt          = s_r;
        s_nxt.fall_req = fire & on_falling;
        if (fire && !on_falling) begin
            s_nxt.rise_tgl = ~s_r.rise_tgl;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Falling-edge launch half a cycle after the request
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fall_tgl_r <= 1'b0;
        end else if (s_r.fall_req) begin
            fall_tgl_r <= ~fall_tgl_r;
        end
    end

    // Only one toggle moves per event, so the level changes once
    assign trig_out = s_r.rise_tgl ^ fall_tgl_r;
endmodule // trigger_edge_launch

// file: hw/trigger_output_cascade_control.sv
// Trigger unit control slice with cascade chaining and AHB-Lite registers
`timescale 1ns/1ps
`include "trigger_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// (RQ1) Chain bit set runs the unit as cascade member, clear runs standalone.
// (RQ2) Tail bit marks the last chain unit, which counts chain iterations.
// (RQ3) With no tail in the chain the iteration count is ignored; loops forever.
// (RQ4) Software stops an endless chain through the unit soft clear bit.
// (RQ5) Two-bit select picks one of three upstream done pulses as start.
// (RQ6) Three-unit ring, unit three tail: selects 0x3, 0x1, 0x2.
// (RQ7) Immediate bit fires at once when target time already passed.
// (RQ8) Immediate bit clear waits until system time reaches the target.
// (RQ9) Notify bit reports done and fault status and raises the interrupt.
// (RQ10) Notify bit clear suppresses both done and fault reporting.
// (RQ11) Edge bit launches output on falling clock edge, else rising.
// (RQ12) Software enables only the head; enable clears once output fires.
// (RQ13) Tail iteration count holds passes minus one: 0 is one pass.
// (RQ14) Done goes downstream as a one-cycle pulse per completion.
module trigger_output_cascade_control
    import trigger_pkg::*;
#(
    parameter int ITER_W = `TRG_ITER_W,
    parameter int TIME_W = `TRG_TIME_W
) (
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // AHB-Lite register port
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    // System time and target time, same clock
    input  wire logic [TIME_W-1:0]          sys_time,
    input  wire logic [TIME_W-1:0]          target_time,
    // Cascade links
    input  wire logic [`TRG_UPSTREAM_N-1:0] upstream_done,
    output logic                            unit_done,
    // Trigger output and interrupt
    output logic                            trig_out,
    output logic                            irq
);
    import trigger_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        seq_state_type          state;
        logic [31:0]            ctrl;
        logic                   enable;
        logic [ITER_W-1:0]      pass_cnt;
        logic                   fire;
        logic                   done;
        logic [`TRG_ST_W-1:0]   status;
        logic [`TRG_ST_W-1:0]   mask;
        logic                   irq;
    } unit_state_type;

    unit_state_type s_r;
    unit_state_type s_nxt;

    logic                   wr_en;
    logic [`TRG_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic                   rd_en;
    logic [`TRG_ADDR_W-1:0] rd_addr;
    logic [31:0]            rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // True when time a lies strictly before time b
    function automatic logic time_before(
        input logic [TIME_W-1:0] a,
        input logic [TIME_W-1:0] b
    );
        time_before = (a < b);
    endfunction

    // Picks the upstream done pulse named by the select field
    function automatic logic upstream_pick(
        input logic [1:0]                 sel,
        input logic [`TRG_UPSTREAM_N-1:0] dn
    );
        unique case (sel)
            2'h0:    upstream_pick = 1'b0;
            2'h1:    upstream_pick = dn[0];
            2'h2:    upstream_pick = dn[1];
            2'h3:    upstream_pick = dn[2];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Field views

    logic              chain_enable;
    logic              tail_unit;
    logic [1:0]        upstream_sel;
    logic              fire_now;
    logic              notify;
    logic              fall_edge;
    logic [ITER_W-1:0] iter_count;
    logic              active;

    assign chain_enable = s_r.ctrl[`TRG_CHAIN_BIT];
    assign tail_unit    = s_r.ctrl[`TRG_TAIL_BIT];
    assign upstream_sel = s_r.ctrl[`TRG_UPSEL_HI:`TRG_UPSEL_LO];
    assign fire_now     = s_r.ctrl[`TRG_NOW_BIT];
    assign notify       = s_r.ctrl[`TRG_NOTIFY_BIT];
    assign fall_edge    = s_r.ctrl[`TRG_EDGE_BIT];
    assign iter_count   = s_r.ctrl[`TRG_ITER_HI:`TRG_ITER_LO];
    assign active       = (s_r.state != ST_IDLE) | s_r.enable;

    ////////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb begin
        rd_data = 32'h00000000;
        unique case (rd_addr)
            `TRG_CTRL_ADDR: rd_data = s_r.ctrl;
            `TRG_RUN_ADDR: begin
                rd_data[`TRG_RUN_EN_BIT]  = s_r.enable;
                rd_data[`TRG_RUN_ACT_BIT] = active;
            end
            `TRG_STAT_ADDR: rd_data[`TRG_ST_W-1:0] = s_r.status;
            `TRG_MASK_ADDR: rd_data[`TRG_ST_W-1:0] = s_r.mask;
            default:        rd_data = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic                 start;
        logic                 late;
        logic [`TRG_ST_W-1:0] st_set;
        start  = 1'b0;
        late   = 1'b0;
        st_set = '0;

        s_nxt      = s_r;
        s_nxt.fire = 1'b0;
        s_nxt.done = 1'b0;

        // Sequencer
        unique case (s_r.state)
            ST_IDLE: begin
                // Head started by software, members by their upstream
                start = s_r.enable | (chain_enable &  // RQ1
                        upstream_pick(upstream_sel, upstream_done)); // RQ5
                late  = time_before(target_time, sys_time);
                if (start) begin
                    if (late && fire_now) begin
                        s_nxt.state = ST_FIRE; // RQ7
                        s_nxt.fire  = 1'b1;
                    end else if (late) begin
                        // Passed target cannot be reached: fault, stop
                        s_nxt.enable = 1'b0;
                        st_set[`TRG_ST_ERR_BIT] = notify; // RQ9 RQ10
                    end else begin
                        s_nxt.state = ST_ARMED; // RQ8
                    end
                end
            end
            ST_ARMED: begin
                if (!time_before(sys_time, target_time)) begin
                    s_nxt.state = ST_FIRE; // RQ8
                    s_nxt.fire  = 1'b1;
                end
            end
            ST_FIRE: begin
                s_nxt.state  = ST_IDLE;
                s_nxt.enable = 1'b0; // RQ12
                st_set[`TRG_ST_DONE_BIT] = notify; // RQ9 RQ10
                if (chain_enable && tail_unit) begin
                    // Tail ends the chain after count plus one passes
                    if (s_r.pass_cnt == iter_count) begin // RQ2 RQ13
                        s_nxt.pass_cnt = '0;
                    end else begin
                        s_nxt.pass_cnt = s_r.pass_cnt + 1'b1;
                        s_nxt.done     = 1'b1; // RQ14
                    end
                end else begin
                    // Non-tail units always pass the start on
                    s_nxt.done = 1'b1; // RQ3 RQ14
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase

        // Register writes
        if (wr_en) begin
            unique case (wr_addr)
                `TRG_CTRL_ADDR: begin
                    s_nxt.ctrl = wr_data & `TRG_CTRL_WMASK;
                end
                `TRG_RUN_ADDR: begin
                    if (wr_data[`TRG_RUN_EN_BIT]) begin
                        s_nxt.enable = 1'b1;
                    end
                end
                `TRG_MASK_ADDR: begin
                    s_nxt.mask = wr_data[`TRG_ST_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Soft clear: back to inactive with default settings
        if (wr_en && wr_addr == `TRG_RUN_ADDR &&
            wr_data[`TRG_RUN_CLR_BIT]) begin
            s_nxt.state    = ST_IDLE; // RQ4
            s_nxt.ctrl     = `TRG_CTRL_RESET;
            s_nxt.enable   = 1'b0;
            s_nxt.pass_cnt = '0;
            s_nxt.fire     = 1'b0;
            s_nxt.done     = 1'b0;
        end

        // Status: read clears, a new event in the same cycle wins
        if (rd_en && rd_addr == `TRG_STAT_ADDR) begin
            s_nxt.status = '0;
        end
        s_nxt.status = s_nxt.status | st_set;

        s_nxt.irq = |(s_nxt.status & s_nxt.mask); // RQ9
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.state    <= ST_IDLE;
            s_r.ctrl     <= `TRG_CTRL_RESET;
            s_r.enable   <= 1'b0;
            s_r.pass_cnt <= '0;
            s_r.fire     <= 1'b0;
            s_r.done     <= 1'b0;
            s_r.status   <= `TRG_ST_RESET;
            s_r.mask     <= `TRG_ST_RESET;
            s_r.irq      <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign unit_done = s_r.done;
    assign irq       = s_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    ahb_lite_regport u_regport (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .rd_en     (rd_en),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data)
    );

    // Edge choice sampled with the fire request
    trigger_edge_launch u_launch (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .fire       (s_r.fire),
        .on_falling (fall_edge), // RQ11
        .trig_out   (trig_out)
    );
endmodule // trigger_output_cascade_control

// file: inc/trigger_defines.svh
// Offsets, field positions, reset values and widths of the trigger unit
`ifndef TRIGGER_DEFINES_SVH
`define TRIGGER_DEFINES_SVH

// Register byte addresses
`define TRG_CTRL_ADDR     12'h538
`define TRG_RUN_ADDR      12'h540
`define TRG_STAT_ADDR     12'h544
`define TRG_MASK_ADDR     12'h548
`define TRG_ADDR_W        12

// Cascade control register fields
`define TRG_CHAIN_BIT     31
`define TRG_TAIL_BIT      30
`define TRG_UPSEL_HI      27
`define TRG_UPSEL_LO      26
`define TRG_NOW_BIT       25
`define TRG_NOTIFY_BIT    24
`define TRG_EDGE_BIT      23
`define TRG_ITER_HI       15
`define TRG_ITER_LO       0
`define TRG_CTRL_WMASK    32'hcf80ffff
`define TRG_CTRL_RESET    32'h00000000

// Run control register fields
`define TRG_RUN_EN_BIT    0
`define TRG_RUN_CLR_BIT   1
`define TRG_RUN_ACT_BIT   2

// Status and mask register fields
`define TRG_ST_DONE_BIT   0
`define TRG_ST_ERR_BIT    1
`define TRG_ST_W          2
`define TRG_ST_RESET      2'h0

// Sizes
`define TRG_ITER_W        16
`define TRG_UPSTREAM_N    3
`define TRG_TIME_W        64

`endif

// file: inc/trigger_pkg.sv
// Types shared by the trigger unit modules
package trigger_pkg;

    // Sequencer states, Gray along idle -> armed -> fire
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_FIRE  = 2'b11
    } seq_state_type;

endpackage
